// ---- bcsr_blank_timer.sv ----
// Purpose: monitor blanking timer started by a setting write
// Assumes: start is a one-cycle pulse
// Notes:   a new start restarts the full interval
`timescale 1ns/1ns
module bcsr_blank_timer #(
    parameter int COUNT = bcsr_pkg::BLANK_CYCLES
)(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic start,
    output logic      blanking
);
    typedef struct packed
    {
        logic [bcsr_pkg::CNT_W-1:0] cnt;
    } bcsr_tmr_s;

    bcsr_tmr_s stQ;
    bcsr_tmr_s stD;

    // refuse a count that the counter cannot hold
    if (COUNT < 1 || COUNT >= (1 << bcsr_pkg::CNT_W))
    begin : g_countCheck
        $error("blank count out of range");
    end

    always_comb
    begin
        stD = stQ;
        if (start)
            stD.cnt = bcsr_pkg::CNT_W'(COUNT);
        else if (stQ.cnt != '0)
            stD.cnt = stQ.cnt - 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            stQ <= '0;
        else
            stQ <= stD;
    end

    assign blanking = (stQ.cnt != '0);
endmodule // bcsr_blank_timer

// ---- bcsr_pkg.sv ----
// Purpose: constants and carrier types for the buck setting register bank
// Assumes: 8-bit registers placed in the low byte of 32-bit wishbone words
// Notes:   offsets are printed subaddresses; byte address is four times the index
package bcsr_pkg;
    localparam logic [7:0]  BUCK2_IDX        = 8'h17;
    localparam logic [7:0]  BUCK3_IDX        = 8'h18;
    localparam logic [7:0]  COMMIT_IDX       = 8'h1a;
    localparam logic [7:0]  UNLOCK_IDX       = 8'h30;
    localparam logic [7:0]  STATUS_IDX       = 8'h31;
    localparam logic [7:0]  BUCK2_RESET      = 8'hb5;
    localparam logic [7:0]  BUCK3_RESET      = 8'h98;
    localparam logic [7:0]  UNLOCK_KEY       = 8'h7d;
    localparam int          SKIP_BIT         = 7;
    localparam int          RSVD_BIT         = 6;
    localparam int          CODE_W           = 6;
    localparam int          COMMIT_BIT       = 0;
    localparam int          COMMIT_DSBL_BIT  = 1;
    localparam logic [7:0]  WRITE_MASK       = 8'hbf;
    localparam int          CLK_HZ           = 10_000_000;
    localparam int          BLANK_MS         = 5;
    localparam int          BLANK_CYCLES     = CLK_HZ / 1000 * BLANK_MS;
    localparam int          CNT_W            = 16;
    localparam logic [6:0]  CODE_BASE2_MV    = 7'h00;

    typedef enum logic [1:0]
    {
        BCSR_IDLE = 2'b00,
        BCSR_ACK  = 2'b01
    } bcsr_bus_e;

    typedef struct packed
    {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [31:0] adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } bcsr_wbreq_s;

    typedef struct packed
    {
        logic [7:0]  buck2Code;
        logic [7:0]  buck3Code;
        logic [15:0] buck2Mv;
        logic [15:0] buck3Mv;
    } bcsr_out_s;
endpackage

// ---- bcsr_regs.sv ----
// Purpose: setting registers of the second and third buck converters
// Assumes: classic wishbone slave, one wait state, 8-bit data in the low lane
// Notes:   the second buck applied code follows its staged code only on a commit write; the third buck code applies at once
`timescale 1ns/1ns

module bcsr_regs #(
    parameter int BLANK_COUNT = bcsr_pkg::BLANK_CYCLES
)(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [31:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 resistorDefaultSelect,
    input  wire logic [5:0]           resistorDefaultCode,
    output logic                      monitorBlank,
    output logic                      buck2PulseSkipEnable,
    output logic                      buck3PulseSkipEnable,
    output logic [5:0]                buck2VoltageCode,
    output logic [5:0]                buck3VoltageCode,
    output logic [15:0]               buck2Millivolt,
    output logic [15:0]               buck3Millivolt
);
    typedef struct packed
    {
        logic        ack;
        logic [7:0]  rdat;
        logic [7:0]  buck2;
        logic [7:0]  buck3;
        logic [5:0]  buck2Applied;
        logic        unlocked;
        logic        strapDone;
    } bcsr_st_s;

    bcsr_st_s stQ;
    bcsr_st_s stD;
    logic     blankStart;
    logic     blanking;

    // second buck code to millivolt
    function automatic logic [15:0] buck2Mv(input logic [5:0] code);
        if (code <= 6'h32)
            buck2Mv = 16'(850 + 10 * int'(code));
        else
            buck2Mv = 16'(1350 + 25 * (int'(code) - 50));
    endfunction

    // third buck code to millivolt
    function automatic logic [15:0] buck3Mv(input logic [5:0] code);
        if (code <= 6'h19)
            buck3Mv = 16'(900 + 25 * int'(code));
        else
            buck3Mv = 16'(1550 + 50 * (int'(code) - 26));
    endfunction

    function automatic logic hit(input logic [31:0] adr, input logic [7:0] idx);
        hit = (adr[31:2] == {22'h0, idx}) && (adr[1:0] == 2'b00);
    endfunction

    logic req;
    logic wr;
    logic lane0;
    logic setHit;
    assign req    = wb_cyc_i && wb_stb_i && !stQ.ack;
    assign wr     = req && wb_we_i;
    assign lane0  = wb_sel_i[0];
    assign setHit = hit(wb_adr_i, bcsr_pkg::BUCK2_IDX) || hit(wb_adr_i, bcsr_pkg::BUCK3_IDX);

    always_comb
    begin
        stD      = stQ;
        stD.ack  = req;
        blankStart = 1'b0;
        // catch strapped default once after reset release
        if (!stQ.strapDone)
        begin
            stD.strapDone = 1'b1;
            if (resistorDefaultSelect)
                stD.buck3 = {bcsr_pkg::BUCK3_RESET[7:6], resistorDefaultCode};
        end
        if (wr && lane0)
        begin
            if (hit(wb_adr_i, bcsr_pkg::UNLOCK_IDX))
                stD.unlocked = (wb_dat_i[7:0] == bcsr_pkg::UNLOCK_KEY);
            else if (setHit && stQ.unlocked)
            begin
                if (hit(wb_adr_i, bcsr_pkg::BUCK2_IDX))
                    stD.buck2 = wb_dat_i[7:0] & bcsr_pkg::WRITE_MASK;
                else
                    stD.buck3 = wb_dat_i[7:0] & bcsr_pkg::WRITE_MASK;
                blankStart   = 1'b1;
                stD.unlocked = 1'b0;
            end
            else if (hit(wb_adr_i, bcsr_pkg::COMMIT_IDX))
            begin
                if (wb_dat_i[bcsr_pkg::COMMIT_BIT] || wb_dat_i[bcsr_pkg::COMMIT_DSBL_BIT])
                    stD.buck2Applied = stQ.buck2[bcsr_pkg::CODE_W-1:0];
            end
        end
        stD.rdat = 8'h00;
        if (req && !wb_we_i)
        begin
            if (hit(wb_adr_i, bcsr_pkg::BUCK2_IDX))
                stD.rdat = stQ.buck2 & bcsr_pkg::WRITE_MASK;
            else if (hit(wb_adr_i, bcsr_pkg::BUCK3_IDX))
                stD.rdat = stQ.buck3 & bcsr_pkg::WRITE_MASK;
            else if (hit(wb_adr_i, bcsr_pkg::STATUS_IDX))
                stD.rdat = {6'h00, blanking, stQ.unlocked};
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            stQ              <= '0;
            stQ.buck2        <= bcsr_pkg::BUCK2_RESET;
            stQ.buck3        <= bcsr_pkg::BUCK3_RESET;
            stQ.buck2Applied <= bcsr_pkg::BUCK2_RESET[5:0];
        end
        else
            stQ <= stD;
    end

    bcsr_blank_timer #(
        .COUNT    (BLANK_COUNT)
    ) u_blank (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .start    (blankStart),
        .blanking (blanking)
    );

    assign monitorBlank         = blanking;
    assign wb_ack_o             = stQ.ack;
    assign wb_dat_o             = {24'h0, stQ.rdat};
    assign buck2PulseSkipEnable = stQ.buck2[bcsr_pkg::SKIP_BIT];
    assign buck3PulseSkipEnable = stQ.buck3[bcsr_pkg::SKIP_BIT];
    assign buck2VoltageCode     = stQ.buck2Applied;
    assign buck3VoltageCode     = stQ.buck3[5:0];
    assign buck2Millivolt       = buck2Mv(stQ.buck2Applied);
    assign buck3Millivolt       = buck3Mv(stQ.buck3[5:0]);
endmodule // bcsr_regs

// ---- bcsr_regs_checker.sv ----
// Purpose: concurrent checks on the buck setting register bank ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   blanking length is checked against a write-age counter
`timescale 1ns/1ns
module bcsr_regs_checker #(
    parameter int BLANK_COUNT = bcsr_pkg::BLANK_CYCLES
)(
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        monitorBlank,
    input wire logic        buck2PulseSkipEnable,
    input wire logic        buck3PulseSkipEnable,
    input wire logic [5:0]  buck2VoltageCode,
    input wire logic [5:0]  buck3VoltageCode,
    input wire logic [15:0] buck2Millivolt,
    input wire logic [15:0] buck3Millivolt
);
    wire         wrA  = wb_cyc_i && wb_stb_i && wb_we_i;
    wire         setW = wrA && (wb_adr_i == 32'h5c || wb_adr_i == 32'h60);
    wire         cmW  = wrA && wb_adr_i == 32'h68 && wb_dat_i[1:0] != 2'h0;
    int unsigned age_q;
    // cycles since the last setting write left the bus
    always_ff @(posedge sys_clk)
        if (reset || setW)
            age_q <= 0;
        else if (age_q < 100000)
            age_q <= age_q + 1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_RSVD_ZERO:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0 && !wb_dat_o[6]) else $error("rsvd set");
    AST_RESET_VALS:
    assert property ($fell(reset) |-> buck2VoltageCode == 6'h35 && buck2PulseSkipEnable
        && buck3VoltageCode == 6'h18 && buck3PulseSkipEnable) else $error("bad reset value");
    AST_BLANK_CAUSE:
    assert property ($rose(monitorBlank) |-> $past(setW) || $past(setW, 2)) else $error("blank");
    AST_BLANK_LEN:
    assert property ($fell(monitorBlank) |-> age_q + 3 >= BLANK_COUNT && age_q <= BLANK_COUNT + 3)
        else $error("blank length");
    AST_COMMIT:
    assert property ($changed(buck2VoltageCode) |-> $past(cmW) || $past(cmW, 2))
        else $error("code applied without commit");
    AST_MV2:
    assert property (buck2Millivolt == ((buck2VoltageCode <= 6'h32)
        ? 16'h0352 + 16'h000a * buck2VoltageCode
        : 16'h0546 + 16'h0019 * (buck2VoltageCode - 6'h32))) else $error("mv2");
    AST_MV3:
    assert property (buck3VoltageCode <= 6'h19 |-> buck3Millivolt
        == 16'h0384 + 16'h0019 * buck3VoltageCode) else $error("mv3");
    AST_MV3_HI:
    assert property (buck3VoltageCode > 6'h19 |-> buck3Millivolt
        == 16'h060e + 16'h0032 * (buck3VoltageCode - 6'h1a)) else $error("mv3 high range");
endmodule // bcsr_regs_checker
bind bcsr_regs bcsr_regs_checker #(.BLANK_COUNT(BLANK_COUNT)) i_bcsr_regs_checker (
    .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .monitorBlank, .buck2PulseSkipEnable, .buck3PulseSkipEnable,
    .buck2VoltageCode, .buck3VoltageCode, .buck2Millivolt, .buck3Millivolt);

// ---- bcsr_regs_tb.sv ----
// Purpose: self-checking bench for the buck setting register bank
// Assumes: blanking shortened to 20 cycles
// Notes:   one classic wishbone cycle per transfer
`timescale 1ns/1ns
module bcsr_regs_tb;
    logic        sys_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        cyc     = 1'b0;
    logic        we      = 1'b0;
    logic [31:0] adr     = 32'h0;
    logic [31:0] wdat    = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack;
    logic        strapSel  = 1'b0;
    logic [5:0]  strapCode = 6'h00;
    logic        blank;
    logic        skip2;
    logic        skip3;
    logic [5:0]  code2;
    logic [5:0]  code3;
    logic [15:0] mv2;
    logic [15:0] mv3;
    int          fails      = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    bcsr_regs #(.BLANK_COUNT(20)) i_bcsr_regs (.sys_clk, .reset, .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .resistorDefaultSelect(strapSel),
        .resistorDefaultCode(strapCode), .monitorBlank(blank), .buck2PulseSkipEnable(skip2),
        .buck3PulseSkipEnable(skip3), .buck2VoltageCode(code2), .buck3VoltageCode(code3),
        .buck2Millivolt(mv2), .buck3Millivolt(mv3));
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        adr  <= {24'h0, a};
        wdat <= {24'h0, d};
        we   <= w;
        cyc  <= 1'b1;
        @(posedge sys_clk);
        while (ack !== 1'b1)
            @(posedge sys_clk);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic t_reset_vals;
        xfer(1'b0, 8'h5c, 8'h00);
        chk(rd, 32'hb5);
        chk(skip2, 1'b1);
        xfer(1'b0, 8'h60, 8'h00);
        chk(rd, 32'h98);
        chk(mv3, 32'h5dc);
    endtask
    task automatic t_locked;
        xfer(1'b1, 8'h5c, 8'h00);
        xfer(1'b0, 8'h5c, 8'h00);
        chk(rd, 32'hb5);
        chk(blank, 1'b0);
    endtask
    task automatic t_commit;
        xfer(1'b1, 8'hc0, 8'h7d);
        xfer(1'b0, 8'hc4, 8'h00);
        chk(rd, 32'h1);
        xfer(1'b1, 8'h5c, 8'hff);
        chk(blank, 1'b1);
        xfer(1'b0, 8'hc4, 8'h00);
        chk(rd, 32'h2);
        xfer(1'b0, 8'h5c, 8'h00);
        chk(rd, 32'hbf);
        chk(code2, 6'h35);
        xfer(1'b1, 8'h68, 8'h02);
        chk(code2, 6'h3f);
        chk(mv2, 32'h68b);
        repeat (25) @(posedge sys_clk);
        chk(blank, 1'b0);
        xfer(1'b1, 8'h5c, 8'h80);
        xfer(1'b0, 8'h5c, 8'h00);
        chk(rd, 32'hbf);
    endtask
    task automatic t_buck3;
        repeat (25) @(posedge sys_clk);
        xfer(1'b1, 8'hc0, 8'h7d);
        xfer(1'b1, 8'h60, 8'h00);
        chk(skip3, 1'b0);
        chk(mv3, 32'h384);
        xfer(1'b0, 8'hfc, 8'h00);
        chk(rd, 32'h0);
    endtask
    task automatic t_strap;
        strapSel  <= 1'b1;
        strapCode <= 6'h3f;
        reset     <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(code3, 6'h3f);
        chk(mv3, 32'hd48);
        xfer(1'b0, 8'h60, 8'h00);
        chk(rd, 32'hbf);
        xfer(1'b1, 8'hc0, 8'h7d);
        xfer(1'b1, 8'h60, 8'h1a);
        chk(mv3, 32'h60e);
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_reset_vals();
        t_locked();
        t_commit();
        t_buck3();
        t_strap();
        stop_test();
    end
endmodule // bcsr_regs_tb
